// ### rtl/eepa_ctrl.sv
// cpu access controller for the on-chip data eeprom behind an axi4-lite slave
// How it works
// - read strobe after address set triggers read
// - read byte lands in data register immediately
// - read stalls core four clock cycles
// - during write, ignore reads and address updates
// - write lasts 27072 rc oscillator cycles
// - master enable self-clears after four cycles
// - strobe clears at write end, two-cycle stall
// - 11-bit linear address, data holds byte
module eepa_ctrl
    import eepa_pkg::*;
#(
    parameter int WRITE_OSC_CYCLES = EEPA_WRITE_OSC_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic rc_osc,
    input wire eepa_axi_req_t axi_req,
    output eepa_axi_rsp_t axi_rsp,
    output logic core_stall,
    output logic write_busy
);

    typedef struct packed {
        eepa_axi_rsp_t rsp;
        logic have_aw;
        logic [7:0] aw_addr;
        logic have_w;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic have_ar;
        logic [7:0] ar_addr;
        logic [EEPA_ADDR_W-1:0] addr;
        logic [EEPA_DATA_W-1:0] data;
        logic [EEPA_STALL_W-1:0] mwe_cnt;
        logic [EEPA_STALL_W-1:0] stall_cnt;
        logic core_stall;
        logic busy_seen;
        logic wr_start;
    } eepa_state_t;

    eepa_state_t st_reg;
    eepa_state_t st_next;

    logic busy;
    logic [EEPA_DATA_W-1:0] mem_rd_data;
    eepa_mem_wr_t mem_wr;

    function automatic eepa_sel_t reg_sel(input logic [7:0] a);
        eepa_sel_t s;
        s = EEPA_SEL_NONE;
        if (a[1:0] == 2'h0) begin
            if (a == EEPA_OFS_ADDR) begin
                s = EEPA_SEL_ADDR;
            end else if (a == EEPA_OFS_DATA) begin
                s = EEPA_SEL_DATA;
            end else if (a == EEPA_OFS_CTRL) begin
                s = EEPA_SEL_CTRL;
            end
        end
        return s;
    endfunction

    // one step of a down counter that rests at zero
    function automatic logic [EEPA_STALL_W-1:0] count_down(input logic [EEPA_STALL_W-1:0] c);
        logic [EEPA_STALL_W-1:0] n;
        n = c;
        if (c != '0) begin
            n = c - 1'b1;
        end
        return n;
    endfunction

    // byte lanes of a register write laid onto the address register
    function automatic logic [EEPA_ADDR_W-1:0] merge_addr(
        input logic [EEPA_ADDR_W-1:0] cur,
        input logic [31:0] d,
        input logic [3:0] be
    );
        logic [EEPA_ADDR_W-1:0] n;
        n = cur;
        if (be[0]) begin
            n[7:0] = d[7:0];
        end
        if (be[1]) begin
            n[EEPA_ADDR_W-1:8] = d[EEPA_ADDR_W-1:8];
        end
        return n;
    endfunction

    // one control bit written with its byte lane enabled
    function automatic logic ctrl_bit(
        input logic [31:0] d,
        input logic [3:0] be,
        input int pos
    );
        return be[0] & d[pos];
    endfunction

    // control register as software reads it, read strobe and spare bits read zero
    function automatic logic [31:0] ctrl_word(input logic wr_busy, input logic armed);
        logic [31:0] w;
        w = '0;
        w[EEPA_BIT_WE] = wr_busy;
        w[EEPA_BIT_MWE] = armed;
        return w;
    endfunction

    // a channel is ready when nothing is held on it and no answer is pending
    function automatic logic chan_ready(input logic held, input logic pending);
        return ~held & ~pending;
    endfunction

    eepa_wtimer #(
        .WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)
    ) u_wtimer (
        .clk(clk),
        .arst_n(arst_n),
        .rc_osc(rc_osc),
        .start(st_reg.wr_start),
        .busy(busy)
    );

    eepa_store u_store (
        .clk(clk),
        .rd_addr(st_reg.addr),
        .rd_data(mem_rd_data),
        .wr_en(mem_wr.we),
        .wr_addr(mem_wr.addr),
        .wr_data(mem_wr.data)
    );

    assign axi_rsp = st_reg.rsp;
    assign core_stall = st_reg.core_stall;
    assign write_busy = st_reg.busy_seen;

    always_comb begin
        logic in_write;
        logic stalled;
        logic mwe_on;
        logic aw_take;
        logic w_take;
        logic b_take;
        logic ar_take;
        logic r_take;
        logic wr_commit;
        logic rd_commit;
        logic lane0;
        logic we_hit;
        logic mwe_hit;
        logic re_hit;
        eepa_sel_t wsel;
        eepa_sel_t rsel;
        logic [31:0] rword;
        in_write = 1'b0;
        stalled = 1'b0;
        mwe_on = 1'b0;
        aw_take = 1'b0;
        w_take = 1'b0;
        b_take = 1'b0;
        ar_take = 1'b0;
        r_take = 1'b0;
        wr_commit = 1'b0;
        rd_commit = 1'b0;
        lane0 = 1'b0;
        we_hit = 1'b0;
        mwe_hit = 1'b0;
        re_hit = 1'b0;
        wsel = EEPA_SEL_NONE;
        rsel = EEPA_SEL_NONE;
        rword = '0;
        st_next = st_reg;
        mem_wr = '0;
        st_next.wr_start = 1'b0;
        in_write = busy | st_reg.wr_start;
        stalled = (st_reg.stall_cnt != '0);
        mwe_on = (st_reg.mwe_cnt != '0);

        // handshakes seen at this edge
        aw_take = axi_req.awvalid & st_reg.rsp.awready;
        w_take = axi_req.wvalid & st_reg.rsp.wready;
        b_take = axi_req.bready & st_reg.rsp.bvalid;
        ar_take = axi_req.arvalid & st_reg.rsp.arready;
        r_take = axi_req.rready & st_reg.rsp.rvalid;
        wr_commit = st_reg.have_aw & st_reg.have_w & ~st_reg.rsp.bvalid & ~stalled;
        rd_commit = st_reg.have_ar & ~st_reg.rsp.rvalid & ~stalled;

        // control bits of a committed write, write strobe wins over read strobe
        lane0 = st_reg.w_strb[0];
        we_hit = ctrl_bit(st_reg.w_data, st_reg.w_strb, EEPA_BIT_WE) & mwe_on & ~in_write;
        mwe_hit = ctrl_bit(st_reg.w_data, st_reg.w_strb, EEPA_BIT_MWE) & ~mwe_on;
        re_hit = ctrl_bit(st_reg.w_data, st_reg.w_strb, EEPA_BIT_RE) & ~in_write & ~we_hit;

        // master enable and core stall count down every cycle
        st_next.mwe_cnt = count_down(st_reg.mwe_cnt);
        st_next.stall_cnt = count_down(st_reg.stall_cnt);

        // address and data channels, taken in either order
        if (aw_take) begin
            st_next.have_aw = 1'b1;
            st_next.aw_addr = axi_req.awaddr;
        end
        if (w_take) begin
            st_next.have_w = 1'b1;
            st_next.w_data = axi_req.wdata;
            st_next.w_strb = axi_req.wstrb;
        end
        if (b_take) begin
            st_next.rsp.bvalid = 1'b0;
        end

        // register write, held off while the core is stalled
        if (wr_commit) begin
            st_next.have_aw = 1'b0;
            st_next.have_w = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp = EEPA_RESP_OKAY;
            wsel = reg_sel(st_reg.aw_addr);
            unique case (wsel)
                EEPA_SEL_ADDR: begin
                    if (!in_write) begin
                        st_next.addr =
                            merge_addr(st_reg.addr, st_reg.w_data, st_reg.w_strb);
                    end
                end
                EEPA_SEL_DATA: begin
                    if (lane0) begin
                        st_next.data = st_reg.w_data[EEPA_DATA_W-1:0];
                    end
                end
                EEPA_SEL_CTRL: begin
                    if (we_hit) begin
                        st_next.wr_start = 1'b1;
                        st_next.mwe_cnt = '0;
                        st_next.stall_cnt = EEPA_WRITE_STALL;
                        mem_wr.we = 1'b1;
                        mem_wr.addr = st_reg.addr;
                        mem_wr.data = st_reg.data;
                    end else if (mwe_hit) begin
                        st_next.mwe_cnt = EEPA_MWE_CYCLES;
                    end
                    if (re_hit) begin
                        st_next.data = mem_rd_data;
                        st_next.stall_cnt = EEPA_READ_STALL;
                    end
                end
                EEPA_SEL_NONE: begin
                    st_next.rsp.bresp = EEPA_RESP_SLVERR;
                end
            endcase
        end

        // read address channel and read answer
        if (ar_take) begin
            st_next.have_ar = 1'b1;
            st_next.ar_addr = axi_req.araddr;
        end
        if (r_take) begin
            st_next.rsp.rvalid = 1'b0;
        end
        if (rd_commit) begin
            st_next.have_ar = 1'b0;
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rresp = EEPA_RESP_OKAY;
            rsel = reg_sel(st_reg.ar_addr);
            unique case (rsel)
                EEPA_SEL_ADDR: begin
                    rword[EEPA_ADDR_W-1:0] = st_reg.addr;
                end
                EEPA_SEL_DATA: begin
                    rword[EEPA_DATA_W-1:0] = st_reg.data;
                end
                EEPA_SEL_CTRL: begin
                    rword = ctrl_word(in_write, mwe_on);
                end
                EEPA_SEL_NONE: begin
                    st_next.rsp.rresp = EEPA_RESP_SLVERR;
                end
            endcase
            st_next.rsp.rdata = rword;
        end

        st_next.rsp.awready = chan_ready(st_next.have_aw, st_next.rsp.bvalid);
        st_next.rsp.wready = chan_ready(st_next.have_w, st_next.rsp.bvalid);
        st_next.rsp.arready = chan_ready(st_next.have_ar, st_next.rsp.rvalid);
        st_next.core_stall = (st_next.stall_cnt != '0);
        // start pulse still counts while the timer has not yet raised its busy
        st_next.busy_seen = busy | st_reg.wr_start | st_next.wr_start;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.addr <= EEPA_ADDR_RST;
            st_reg.data <= EEPA_DATA_RST;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// ### rtl/eepa_pkg.sv
// shared constants and carrier types for the eeprom access controller
package eepa_pkg;

    localparam int EEPA_ADDR_W = 11;
    localparam int EEPA_DATA_W = 8;
    localparam int EEPA_STALL_W = 3;
    localparam int EEPA_TIMER_W = 15;

    localparam logic [7:0] EEPA_OFS_ADDR = 8'h00;
    localparam logic [7:0] EEPA_OFS_DATA = 8'h04;
    localparam logic [7:0] EEPA_OFS_CTRL = 8'h08;

    localparam int EEPA_BIT_RE = 0;
    localparam int EEPA_BIT_WE = 1;
    localparam int EEPA_BIT_MWE = 2;

    localparam logic [EEPA_ADDR_W-1:0] EEPA_ADDR_RST = 11'h000;
    localparam logic [EEPA_DATA_W-1:0] EEPA_DATA_RST = 8'h00;

    localparam logic [EEPA_STALL_W-1:0] EEPA_READ_STALL = 3'h4;
    localparam logic [EEPA_STALL_W-1:0] EEPA_WRITE_STALL = 3'h2;
    localparam logic [EEPA_STALL_W-1:0] EEPA_MWE_CYCLES = 3'h4;
    localparam int EEPA_WRITE_OSC_CYCLES = 27072;

    localparam logic [1:0] EEPA_RESP_OKAY = 2'h0;
    localparam logic [1:0] EEPA_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        EEPA_SEL_ADDR = 2'b00,
        EEPA_SEL_DATA = 2'b01,
        EEPA_SEL_CTRL = 2'b10,
        EEPA_SEL_NONE = 2'b11
    } eepa_sel_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } eepa_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } eepa_axi_rsp_t;

    typedef struct packed {
        logic we;
        logic [EEPA_ADDR_W-1:0] addr;
        logic [EEPA_DATA_W-1:0] data;
    } eepa_mem_wr_t;

endpackage

// ### rtl/eepa_store.sv
// byte-wide nonvolatile array model with immediate read and single write port
module eepa_store
    import eepa_pkg::*;
#(
    parameter int ADDR_W = EEPA_ADDR_W,
    parameter int DATA_W = EEPA_DATA_W
) (
    input wire logic clk,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // linear byte addressing, read is combinational
    assign rd_data = mem[rd_addr];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule

// ### rtl/eepa_wtimer.sv
// write duration timer counting calibrated rc oscillator cycles
module eepa_wtimer
    import eepa_pkg::*;
#(
    parameter int WRITE_OSC_CYCLES = EEPA_WRITE_OSC_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic rc_osc,
    input wire logic start,
    output logic busy
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic osc_prev;
        logic busy;
        logic [EEPA_TIMER_W-1:0] cnt;
    } eepa_wt_state_t;

    localparam logic [EEPA_TIMER_W-1:0] LAST = EEPA_TIMER_W'(WRITE_OSC_CYCLES - 1);

    eepa_wt_state_t st_reg;
    eepa_wt_state_t st_next;
    logic tick;

    // rising edge of the synchronised oscillator
    assign tick = st_reg.sync2 & ~st_reg.osc_prev;
    assign busy = st_reg.busy;

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = rc_osc;
        st_next.sync2 = st_reg.sync1;
        st_next.osc_prev = st_reg.sync2;
        if (start && !st_reg.busy) begin
            st_next.busy = 1'b1;
            st_next.cnt = '0;
        end else if (st_reg.busy && tick) begin
            if (st_reg.cnt == LAST) begin
                st_next.busy = 1'b0;
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// ### verif/eepa_ctrl_bench.sv
// self-checking bench for the eeprom access controller
module eepa_ctrl_bench
    import eepa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OSC = 6;
    localparam logic [31:0] RE = 32'h1 << EEPA_BIT_RE;
    localparam logic [31:0] WE = 32'h1 << EEPA_BIT_WE;
    localparam logic [31:0] MWE = 32'h1 << EEPA_BIT_MWE;
    localparam logic [1:0] OK = EEPA_RESP_OKAY;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic rc_osc = 1'b0;
    eepa_axi_req_t req = '{bready: 1'b1, default: '0};
    eepa_axi_rsp_t rsp;
    logic core_stall;
    logic write_busy;
    int n_fail = 0;
    int tests_run = 0;
    int run_len = 0;
    int last_run = 0;
    int rc_div = 0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        rc_div <= rc_div + 1;
        if (rc_div % 4 == 3) rc_osc <= ~rc_osc;
    end
    // length of the most recent stall run
    always @(posedge clk) begin
        if (core_stall === 1'b1) run_len <= run_len + 1;
        else if (run_len != 0) begin
            last_run <= run_len;
            run_len <= 0;
        end
    end
    eepa_ctrl #(.WRITE_OSC_CYCLES(OSC)) dut (.clk(clk), .arst_n(arst_n), .rc_osc(rc_osc),
        .axi_req(req), .axi_rsp(rsp), .core_stall(core_stall), .write_busy(write_busy));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d fails=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = OK);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        forever begin
            @(posedge clk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) break;
        end
        chk({29'h0, rsp.bvalid, rsp.bresp}, {29'h0, 1'b1, er});
    endtask
    task automatic rd(input logic [7:0] a, input int dly, output logic [31:0] d,
        output logic [1:0] r);
        int i;
        i = 0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= (dly == 0);
        forever begin
            @(posedge clk);
            i++;
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (i == dly) req.rready <= 1'b1;
            if (rsp.rvalid === 1'b1 && req.rready === 1'b1) break;
        end
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = OK,
        input int dly = 0);
        logic [31:0] v;
        logic [1:0] r;
        rd(a, dly, v, r);
        chk(v, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic wbyte(input logic [31:0] a, input logic [31:0] d);
        wait_idle();
        wr(EEPA_OFS_ADDR, a);
        wr(EEPA_OFS_DATA, d);
        wr(EEPA_OFS_CTRL, MWE);
        wr(EEPA_OFS_CTRL, WE);
        repeat (6) @(posedge clk);
        chk({31'h0, write_busy}, 32'h1);
        chk(32'(last_run), 32'h2);
    endtask
    task automatic wait_idle();
        logic [31:0] v;
        logic [1:0] r;
        forever begin
            rd(EEPA_OFS_CTRL, 0, v, r);
            if (v[EEPA_BIT_WE] === 1'b0) break;
        end
        chk(v & WE, 32'h0);
    endtask
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        wr(EEPA_OFS_ADDR, 32'hFFFF);
        rc(EEPA_OFS_ADDR, 32'h7FF);
        wbyte(32'h7FF, 32'h5A);
        wait_idle();
        wbyte(32'h005, 32'hA5);
        wr(EEPA_OFS_DATA, 32'h3C);
        wr(EEPA_OFS_ADDR, 32'h001);
        wr(EEPA_OFS_CTRL, RE);
        rc(EEPA_OFS_DATA, 32'h3C);
        rc(EEPA_OFS_ADDR, 32'h005);
        rc(EEPA_OFS_CTRL, WE);
        wait_idle();
        wr(EEPA_OFS_CTRL, RE);
        rc(EEPA_OFS_DATA, 32'hA5);
        chk(32'(last_run), 32'h4);
        rc(EEPA_OFS_CTRL, 32'h0);
        wr(EEPA_OFS_ADDR, 32'h7FF);
        wr(EEPA_OFS_CTRL, RE);
        rc(EEPA_OFS_DATA, 32'h5A, OK, 3);
        wr(EEPA_OFS_CTRL, MWE);
        repeat (8) @(posedge clk);
        wr(EEPA_OFS_CTRL, WE);
        repeat (4) @(posedge clk);
        chk({31'h0, write_busy}, 32'h0);
        wr(EEPA_OFS_CTRL, MWE | WE);
        chk({31'h0, write_busy}, 32'h0);
        wr(EEPA_OFS_CTRL, WE);
        repeat (6) @(posedge clk);
        chk({31'h0, write_busy}, 32'h1);
        wait_idle();
        wr(8'h0C, 32'h1, EEPA_RESP_SLVERR);
        wr(8'h02, 32'h1, EEPA_RESP_SLVERR);
        rc(8'h0C, 32'h0, EEPA_RESP_SLVERR, 3);
        wrap_up();
    end
endmodule

// ### verif/eepa_ctrl_checker.sv
// assertion checker for the eeprom access controller ports
module eepa_ctrl_checker
    import eepa_pkg::*;
#(
    parameter int WRITE_OSC_CYCLES = EEPA_WRITE_OSC_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic rc_osc,
    input wire eepa_axi_req_t axi_req,
    input wire eepa_axi_rsp_t axi_rsp,
    input wire logic core_stall,
    input wire logic write_busy
);
    logic rc_reg;
    logic [15:0] cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // counts oscillator rising edges while a write runs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rc_reg <= 1'b0;
            cnt_reg <= 16'h0000;
        end else begin
            rc_reg <= rc_osc;
            cnt_reg <= !write_busy ? 16'h0000 : cnt_reg + 16'(rc_osc && !rc_reg);
        end
    end
    sequence two_s;
        core_stall [*2] ##1 !core_stall;
    endsequence
    sequence four_s;
        core_stall [*4] ##1 !core_stall;
    endsequence
    stall_len_a: assert property ($rose(core_stall) |-> two_s or four_s)
        else $error("core stall run is neither two nor four cycles");
    start_stall_a: assert property ($rose(write_busy) |-> core_stall || $past(core_stall))
        else $error("write started without a core stall");
    busy_min_a: assert property ($fell(write_busy) |-> int'(cnt_reg) >= WRITE_OSC_CYCLES - 1)
        else $error("write ended too early");
    busy_max_a: assert property (write_busy |-> int'(cnt_reg) <= WRITE_OSC_CYCLES + 1)
        else $error("write ran too long");
    rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
        axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read answer dropped or changed before rready");
    rd_pend_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("arready high while read answer pending");
    wr_pend_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write ready high while write answer pending");
    addr_width_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:11] == 21'h000000)
        else $error("read data has bits above the address width");
    err_zero_a: assert property (axi_rsp.rvalid && axi_rsp.rresp == EEPA_RESP_SLVERR |->
        axi_rsp.rdata == 32'h00000000)
        else $error("refused read returned nonzero data");
endmodule

bind eepa_ctrl eepa_ctrl_checker #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)) chk_i (.clk(clk),
    .arst_n(arst_n), .rc_osc(rc_osc), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .core_stall(core_stall), .write_busy(write_busy));
